// ===== vpa_datapath.sv
// result fifo and the pointwise vector arithmetic engine
// assumes operand reads return data exactly one clock after the read enable,
// and the memory write port may stall through wr_ready
`timescale 1ns/100ps
// Overview of operation
// - decode 0x74, 0x78, 0x70 to their operations
// - packed multiply handles two q15 lanes per step
// - packed pointers address a pair of elements
// - packed multiply is lane wise q15, pairs
// - outside mac, each pointer adds its own signed step
// - unsigned count sets number of elements; packed odd counts round up to a pair
// - q31 multiply, one 32-bit element per step
// - complex multiply on q15 real/imag pairs
// - real xr*yr-xi*yi, imag xi*yr+xr*yi
// - complex and packed subtract saturate at q15
// - packed subtract x minus y, two lanes
// - 32-bit subtract x minus y per element
// - 32-bit subtract and mac saturate at q31
// - mac sums widened q15 products into 48 bits
// - mac writes one word, no caller increments
// - negative steps walk vectors downward
// - matrices and complex are flat element runs

// ****************************************************
// result fifo
// ****************************************************
module vpa_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    input wire logic clk,                                // core clock
    input wire logic reset,                              // async reset, high
    input wire logic in_valid,                           // write request
    output logic in_ready,                               // room for a word
    input wire logic [WIDTH-1:0] in_data,                // word to store
    output logic out_valid,                              // word available
    input wire logic out_ready,                          // drain accepts word
    output logic [WIDTH-1:0] out_data,                   // oldest word
    output logic empty                                   // nothing stored
);
    localparam int AW = $clog2(DEPTH);
    // pointer wrap relies on a power of two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];                     // storage
    logic [AW:0] wp_r;                                   // write pointer with wrap bit
    logic [AW:0] rp_r;                                   // read pointer with wrap bit
    logic full;
    assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty = (wp_r == rp_r);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rp_r[AW-1:0]];
    // storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (in_valid && !full) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
    // pointers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && !full) begin
                wp_r <= wp_r + 1'b1;
            end
            if (out_ready && !empty) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end
endmodule

// ****************************************************
// vector engine
// ****************************************************
module vpa_datapath #(
    parameter int FIFO_DEPTH = vpa_pkg::FIFO_DEPTH
) (
    input wire logic clk,                                // 250 mhz core clock
    input wire logic reset,                              // async reset, high
    input wire logic cmd_start,                          // one cycle command strobe
    input wire vpa_pkg::vpa_cmd_type cmd,                // parameter block
    output logic busy,                                   // command in progress
    output logic done,                                   // one cycle at completion
    output logic cmd_error,                              // unknown code, registered
    output logic x_rd_en,                                // x operand read
    output logic [15:0] x_rd_addr,                       // x read address
    input wire logic [31:0] x_rd_data,                   // x data, one clock later
    output logic y_rd_en,                                // y operand read
    output logic [15:0] y_rd_addr,                       // y read address
    input wire logic [31:0] y_rd_data,                   // y data, one clock later
    output logic wr_valid,                               // result write request
    input wire logic wr_ready,                           // memory takes the write
    output vpa_pkg::vpa_wr_type wr                       // address and result
);
    if (FIFO_DEPTH < 2) begin : g_chk
        $error("fifo depth too small");
    end
    vpa_pkg::vpa_state_type st_r;                        // engine state
    logic [7:0] op_r;                                    // latched command code
    logic [15:0] x_ptr_r, y_ptr_r, z_ptr_r;              // live pointers
    logic [15:0] x_inc_r, y_inc_r, z_inc_r;              // signed steps
    logic [16:0] left_r;                                 // steps still to do
    logic [31:0] res_r;                                  // result word
    logic signed [47:0] acc_r;                           // wide mac accumulator
    logic fifo_in_ready, fifo_empty;
    logic known_op, packed_op, is_mac, last_step;
    logic [16:0] steps;

    // ****************************************************
    // saturation helpers
    // ****************************************************
    // clamp a wide value to q15, never wrapping
    function automatic logic [15:0] sat16(input logic signed [33:0] v);
        if (v > $signed({18'h00000, vpa_pkg::Q15_MAX})) begin
            return vpa_pkg::Q15_MAX;
        end else if (v < $signed({18'h3ffff, vpa_pkg::Q15_MIN})) begin
            return vpa_pkg::Q15_MIN;
        end else begin
            return v[15:0];
        end
    endfunction
    // clamp a wide value to q31
    function automatic logic [31:0] sat32(input logic signed [63:0] v);
        if (v > $signed({32'h00000000, vpa_pkg::Q31_MAX})) begin
            return vpa_pkg::Q31_MAX;
        end else if (v < $signed({32'hffffffff, vpa_pkg::Q31_MIN})) begin
            return vpa_pkg::Q31_MIN;
        end else begin
            return v[31:0];
        end
    endfunction

    // ****************************************************
    // decode
    // ****************************************************
    always_comb begin
        case (cmd.opcode)
            vpa_pkg::OPC_PMUL, vpa_pkg::OPC_PSUB, vpa_pkg::OPC_MAC: packed_op = 1'b1;
            default: packed_op = 1'b0;
        endcase
        case (cmd.opcode)
            vpa_pkg::OPC_PMUL, vpa_pkg::OPC_LMUL, vpa_pkg::OPC_CMUL,
            vpa_pkg::OPC_PSUB, vpa_pkg::OPC_LSUB, vpa_pkg::OPC_MAC: known_op = 1'b1;
            default: known_op = 1'b0;
        endcase
    end
    // packed commands do two elements a step; odd counts round up, pad is caller's
    assign steps = packed_op ? ((17'({1'b0, cmd.count}) + vpa_pkg::CNT_ONE) >> 1)
                             : 17'({1'b0, cmd.count});
    assign is_mac = (op_r == vpa_pkg::OPC_MAC);
    assign last_step = (left_r == vpa_pkg::CNT_ONE);

    // ****************************************************
    // arithmetic, two q15 lanes or one q31 value per word
    // ****************************************************
    logic [15:0] pmul_lane [2];                          // packed multiply lanes
    logic [15:0] psub_lane [2];                          // packed subtract lanes
    logic signed [32:0] mac_prod [2];                    // doubled products, one guard bit
    for (genvar i = 0; i < 2; i++) begin : g_lane
        logic signed [15:0] xa, ya;
        logic signed [31:0] prod;
        assign xa = x_rd_data[16*i +: 16];
        assign ya = y_rd_data[16*i +: 16];
        assign prod = xa * ya;
        // truncating shift keeps q15 alignment; only -1*-1 can overflow
        assign pmul_lane[i] = sat16(34'(prod >>> vpa_pkg::Q15_FRAC));
        assign psub_lane[i] = sat16(34'(xa) - 34'(ya));
        // minus one squared doubles to 2^31, which a 32-bit lane would wrap
        assign mac_prod[i] = 33'(prod) <<< 1;
    end
    // complex: low half real, high half imaginary
    logic signed [15:0] xr, xi, yr, yi;
    logic signed [33:0] c_re, c_im;
    logic signed [63:0] lmul;
    assign xr = x_rd_data[15:0];
    assign xi = x_rd_data[31:16];
    assign yr = y_rd_data[15:0];
    assign yi = y_rd_data[31:16];
    assign c_re = 34'(xr * yr) - 34'(xi * yi);
    assign c_im = 34'(xi * yr) + 34'(xr * yi);
    assign lmul = $signed(x_rd_data) * $signed(y_rd_data);

    // ****************************************************
    // control state machine
    // ****************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= vpa_pkg::VPA_IDLE;
        end else begin
            case (st_r)
                vpa_pkg::VPA_IDLE: begin
                    if (cmd_start && known_op) begin
                        st_r <= (steps == vpa_pkg::CNT_ZERO) ? vpa_pkg::VPA_FLUSH
                                                              : vpa_pkg::VPA_READ;
                    end
                end
                vpa_pkg::VPA_READ: st_r <= vpa_pkg::VPA_CALC;
                vpa_pkg::VPA_CALC: begin
                    // mac stores only once, after its last pair
                    if (!is_mac || last_step) begin
                        st_r <= vpa_pkg::VPA_PUSH;
                    end else begin
                        st_r <= vpa_pkg::VPA_READ;
                    end
                end
                vpa_pkg::VPA_PUSH: begin
                    // a full fifo holds the engine here: back pressure
                    if (fifo_in_ready) begin
                        st_r <= last_step ? vpa_pkg::VPA_FLUSH : vpa_pkg::VPA_READ;
                    end
                end
                vpa_pkg::VPA_FLUSH: begin
                    if (fifo_empty) begin
                        st_r <= vpa_pkg::VPA_IDLE;
                    end
                end
                default: st_r <= vpa_pkg::VPA_IDLE;
            endcase
        end
    end

    // ****************************************************
    // command latch, pointers and step count
    // ****************************************************
    // pointers are flat addresses; no matrix or complex layout is applied
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            op_r <= '0;
            x_ptr_r <= '0;
            y_ptr_r <= '0;
            z_ptr_r <= '0;
            x_inc_r <= '0;
            y_inc_r <= '0;
            z_inc_r <= '0;
            left_r <= '0;
        end else if (st_r == vpa_pkg::VPA_IDLE && cmd_start && known_op) begin
            op_r <= cmd.opcode;
            x_ptr_r <= cmd.x_ptr;
            y_ptr_r <= cmd.y_ptr;
            z_ptr_r <= cmd.z_ptr;
            // mac ignores caller steps and walks pairs upward
            x_inc_r <= (cmd.opcode == vpa_pkg::OPC_MAC) ? vpa_pkg::PAIR_STEP : cmd.x_pointer_step;
            y_inc_r <= (cmd.opcode == vpa_pkg::OPC_MAC) ? vpa_pkg::PAIR_STEP : cmd.y_pointer_step;
            z_inc_r <= cmd.z_pointer_step;
            left_r <= steps;
        end else if ((st_r == vpa_pkg::VPA_CALC && is_mac && !last_step) ||
                     (st_r == vpa_pkg::VPA_PUSH && fifo_in_ready)) begin
            x_ptr_r <= x_ptr_r + x_inc_r;
            y_ptr_r <= y_ptr_r + y_inc_r;
            if (!is_mac) begin
                z_ptr_r <= z_ptr_r + z_inc_r;
            end
            left_r <= left_r - vpa_pkg::CNT_ONE;
        end
    end

    // ****************************************************
    // result and accumulator
    // ****************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            res_r <= '0;
            acc_r <= '0;
        end else if (st_r == vpa_pkg::VPA_IDLE) begin
            acc_r <= '0;
        end else if (st_r == vpa_pkg::VPA_CALC) begin
            case (op_r)
                vpa_pkg::OPC_PMUL: res_r <= {pmul_lane[1], pmul_lane[0]};
                vpa_pkg::OPC_PSUB: res_r <= {psub_lane[1], psub_lane[0]};
                vpa_pkg::OPC_LMUL: res_r <= sat32(lmul >>> vpa_pkg::Q31_FRAC);
                vpa_pkg::OPC_CMUL: begin
                    res_r <= {sat16(c_im >>> vpa_pkg::Q15_FRAC),
                              sat16(c_re >>> vpa_pkg::Q15_FRAC)};
                end
                vpa_pkg::OPC_LSUB: begin
                    res_r <= sat32(64'($signed(x_rd_data)) - 64'($signed(y_rd_data)));
                end
                vpa_pkg::OPC_MAC: begin
                    // wide sum, clamped once so partial overflow is harmless
                    acc_r <= acc_r + 48'(mac_prod[0]) + 48'(mac_prod[1]);
                    res_r <= sat32(64'(acc_r + 48'(mac_prod[0]) + 48'(mac_prod[1])));
                end
                default: res_r <= res_r;
            endcase
        end
    end

    // unknown command code reported for one cycle, command dropped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_error <= 1'b0;
        end else begin
            cmd_error <= (st_r == vpa_pkg::VPA_IDLE) && cmd_start && !known_op;
        end
    end

    // ****************************************************
    // ports and fifo
    // ****************************************************
    assign busy = (st_r != vpa_pkg::VPA_IDLE);
    assign done = (st_r == vpa_pkg::VPA_FLUSH) && fifo_empty;
    assign x_rd_en = (st_r == vpa_pkg::VPA_READ);
    assign y_rd_en = (st_r == vpa_pkg::VPA_READ);
    assign x_rd_addr = x_ptr_r;
    assign y_rd_addr = y_ptr_r;
    vpa_fifo #(.WIDTH($bits(vpa_pkg::vpa_wr_type)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(st_r == vpa_pkg::VPA_PUSH),
        .in_ready(fifo_in_ready),
        .in_data({z_ptr_r, res_r}),
        .out_valid(wr_valid),
        .out_ready(wr_ready),
        .out_data(wr),
        .empty(fifo_empty)
    );

    // ****************************************************
    // checks
    // ****************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [16:0] chk_done_r;                             // steps actually finished
    logic [16:0] chk_total_r;                            // steps expected
    logic [1:0] chk_mac_push_r;                          // mac stores seen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chk_done_r <= '0;
            chk_total_r <= '0;
            chk_mac_push_r <= '0;
        end else if (st_r == vpa_pkg::VPA_IDLE) begin
            chk_done_r <= '0;
            chk_total_r <= steps;
            chk_mac_push_r <= '0;
        end else begin
            if ((st_r == vpa_pkg::VPA_CALC && is_mac) ||
                (st_r == vpa_pkg::VPA_PUSH && fifo_in_ready && !is_mac)) begin
                chk_done_r <= chk_done_r + vpa_pkg::CNT_ONE;
            end
            if (st_r == vpa_pkg::VPA_PUSH && fifo_in_ready && is_mac) begin
                chk_mac_push_r <= chk_mac_push_r + 2'h1;
            end
        end
    end
    AST_DECODE_LONG: assert property (st_r == vpa_pkg::VPA_IDLE && cmd_start && cmd.opcode == vpa_pkg::OPC_LMUL |=> op_r == vpa_pkg::OPC_LMUL && busy)
        else $error("q31 multiply code not latched");
    AST_PTR_STEP: assert property (st_r == vpa_pkg::VPA_PUSH && fifo_in_ready && !is_mac |=> x_ptr_r == $past(x_ptr_r) + $past(x_inc_r) && z_ptr_r == $past(z_ptr_r) + $past(z_inc_r))
        else $error("pointer did not advance by its step");
    AST_MAC_Z_HOLD: assert property (busy && is_mac |=> $stable(z_ptr_r))
        else $error("mac destination pointer moved");
    AST_STEP_COUNT: assert property (done |-> chk_done_r == chk_total_r)
        else $error("wrong number of element steps");
    AST_MAC_ONCE: assert property (is_mac |-> chk_mac_push_r <= 2'h1)
        else $error("mac stored more than one result");
    AST_SUB32_SAT: assert property (st_r == vpa_pkg::VPA_CALC && op_r == vpa_pkg::OPC_LSUB && x_rd_data[31] != y_rd_data[31] |=> res_r[31] == $past(x_rd_data[31]))
        else $error("32-bit subtract wrapped");
    AST_SUB16_SAT: assert property (st_r == vpa_pkg::VPA_CALC && op_r == vpa_pkg::OPC_PSUB && x_rd_data[15] != y_rd_data[15] |=> res_r[15] == $past(x_rd_data[15]))
        else $error("packed subtract wrapped");
    AST_PMUL_CLAMP: assert property (st_r == vpa_pkg::VPA_CALC && op_r == vpa_pkg::OPC_PMUL && x_rd_data[31:16] == vpa_pkg::Q15_MIN && y_rd_data[31:16] == vpa_pkg::Q15_MIN |=> res_r[31:16] == vpa_pkg::Q15_MAX)
        else $error("packed multiply minus one squared not clamped");
    AST_STALL: assert property (st_r == vpa_pkg::VPA_PUSH && !fifo_in_ready |=> st_r == vpa_pkg::VPA_PUSH && $stable(res_r))
        else $error("result lost while fifo full");
endmodule

// ===== vpa_datapath_tb_top.sv
// self-checking bench for the vector engine with a memory model behind it
// assumes expected results are truncated products then saturated
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("unexpected at %0t: %h not %h", $time, a, b); end end
// ****
// bench top
// ****
module vpa_datapath_tb_top;
    logic clk = 0, reset = 1, cmd_start = 0, hold = 0, busy, done, cmd_error;
    logic x_rd_en, y_rd_en, wr_valid, wr_ready;
    logic [15:0] x_rd_addr, y_rd_addr;
    logic [31:0] x_rd_data, y_rd_data;
    vpa_pkg::vpa_cmd_type cmd = '0;
    vpa_pkg::vpa_wr_type wr;
    int seed = 27, num_errors = 0, checked = 0, cycles = 0, i, n;
    logic [7:0] op;
    logic [7:0] ops [6] = '{vpa_pkg::OPC_PMUL, vpa_pkg::OPC_LMUL, vpa_pkg::OPC_CMUL,
        vpa_pkg::OPC_PSUB, vpa_pkg::OPC_LSUB, vpa_pkg::OPC_MAC};
    always #2 clk = ~clk;
    vpa_datapath i_vpa_datapath (.clk, .reset, .cmd_start, .cmd, .busy, .done, .cmd_error,
        .x_rd_en, .x_rd_addr, .x_rd_data, .y_rd_en, .y_rd_addr, .y_rd_data,
        .wr_valid, .wr_ready, .wr);
    vpa_mem_model i_vpa_mem_model (.clk, .hold, .x_rd_en, .x_rd_addr, .x_rd_data,
        .y_rd_en, .y_rd_addr, .y_rd_data, .wr_valid, .wr_ready, .wr);
    function automatic logic [31:0] sat(longint v, int w);
        longint m;
        m = longint'(1) <<< (w - 1);
        return v >= m ? 32'(m - 1) : (v < -m ? 32'(-m) : 32'(v));
    endfunction
    // expected word; for accumulate the unclamped doubled lane sum
    function automatic longint ev(logic [7:0] o, logic [31:0] x, logic [31:0] y);
        longint a0, a1, b0, b1;
        logic [31:0] l, h;
        a0 = $signed(x[15:0]);
        a1 = $signed(x[31:16]);
        b0 = $signed(y[15:0]);
        b1 = $signed(y[31:16]);
        case (o)
            vpa_pkg::OPC_LMUL: return sat((longint'($signed(x)) * $signed(y)) >>> 31, 32);
            vpa_pkg::OPC_LSUB: return sat(longint'($signed(x)) - $signed(y), 32);
            vpa_pkg::OPC_MAC: return (a0 * b0 + a1 * b1) * 2;
            vpa_pkg::OPC_PMUL: begin
                l = sat((a0 * b0) >>> 15, 16);
                h = sat((a1 * b1) >>> 15, 16);
            end
            vpa_pkg::OPC_CMUL: begin
                l = sat((a0 * b0 - a1 * b1) >>> 15, 16);
                h = sat((a1 * b0 + a0 * b1) >>> 15, 16);
            end
            default: begin
                l = sat(a0 - b0, 16);
                h = sat(a1 - b1, 16);
            end
        endcase
        return {h[15:0], l[15:0]};
    endfunction
    // one command: fill memory, start, wait, compare every destination word
    task automatic run(logic [7:0] o, int nn, logic [15:0] s);
        int st, k, cnt;
        longint acc, e;
        logic [15:0] a, r;
        logic pk, c;
        pk = o == vpa_pkg::OPC_PMUL || o == vpa_pkg::OPC_PSUB || o == vpa_pkg::OPC_MAC;
        st = pk ? (nn + 1) / 2 : nn;
        r = (o == vpa_pkg::OPC_MAC) ? 16'h0002 : s;
        for (k = -32; k <= 32; k++) begin
            a = 16'(k);
            c = (k % 4 == 1) || (k == 2); // minus one corners, offset 2 reached by step 2 and mac
            i_vpa_mem_model.mem[16'h1010 + a] = c ? 32'h80008000 : $random(seed);
            i_vpa_mem_model.mem[16'h2010 + a] = c ? 32'h80008000 : $random(seed);
            i_vpa_mem_model.mem[16'h3010 + a] = 32'h5a5a5a5a;
        end
        @(negedge clk);
        cmd = {o, 16'h1010, 16'h2010, 16'h3010, s, s, s, 16'(nn)};
        cmd_start = 1;
        @(negedge clk);
        cmd_start = 0;
        `CHK(busy, 1'b1)
        cnt = 0;
        while (done !== 1'b1 && cnt < 600) begin
            if (cnt == 150) begin
                `CHK({busy, wr_valid}, 2'b11)
                hold = 0;
            end
            @(negedge clk);
            cnt++;
        end
        `CHK(done, 1'b1)
        @(negedge clk);
        acc = 0;
        for (k = 0; k < st; k++) begin
            e = ev(o, i_vpa_mem_model.mem[16'h1010 + 16'(k) * r],
                i_vpa_mem_model.mem[16'h2010 + 16'(k) * r]);
            acc += e;
            if (o != vpa_pkg::OPC_MAC) `CHK(i_vpa_mem_model.mem[16'h3010 + 16'(k) * s], e[31:0])
        end
        if (o == vpa_pkg::OPC_MAC) `CHK(i_vpa_mem_model.mem[16'h3010], sat(acc, 32))
        a = 16'h3010 + 16'(pk && o == vpa_pkg::OPC_MAC ? 1 : st) * s;
        `CHK(i_vpa_mem_model.mem[a], 32'h5a5a5a5a)
        $display("test op %h n %0d step %h done", o, nn, s);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard, far above the thousand or so cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            give_verdict;
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        reset = 0;
        @(negedge clk);
        cmd_start = 1;
        @(negedge clk);
        cmd_start = 0;
        `CHK({cmd_error, busy}, 2'b10)
        run(vpa_pkg::OPC_LSUB, 0, 16'h0001);
        hold = 1;
        run(vpa_pkg::OPC_LSUB, 24, 16'h0001);
        for (i = 0; i < 48; i++) begin
            op = ops[i % 6];
            n = ($random(seed) & 7) + 1;
            if (op == vpa_pkg::OPC_PMUL || op == vpa_pkg::OPC_PSUB || op == vpa_pkg::OPC_MAC) n += n % 2;
            run(op, n, ($random(seed) & 1) ? 16'hffff : 16'h0002);
        end
        give_verdict;
    end
endmodule

// ===== vpa_mem_model.sv
// local data memory seen by the vector engine, one 32-bit word per address
// assumes reads are answered one clock after the strobe, writes may stall
`timescale 1ns/100ps
// ****
// memory model
// ****
module vpa_mem_model (
    input wire logic clk,                       // core clock
    input wire logic hold,                      // refuse all writes
    input wire logic x_rd_en,                   // x read strobe
    input wire logic [15:0] x_rd_addr,          // x address
    output logic [31:0] x_rd_data,              // x word
    input wire logic y_rd_en,                   // y read strobe
    input wire logic [15:0] y_rd_addr,          // y address
    output logic [31:0] y_rd_data,              // y word
    input wire logic wr_valid,                  // result waiting
    output logic wr_ready,                      // write taken
    input wire vpa_pkg::vpa_wr_type wr          // address and result
);
    logic [31:0] mem [0:65535];                 // whole 16-bit space
    int seed = 9;                               // own stall pattern
    initial begin
        x_rd_data = '0;
        y_rd_data = '0;
        wr_ready = 1'b0;
    end
    // no read: junk that flips every cycle, so stale data never looks right
    always @(posedge clk) begin
        x_rd_data <= x_rd_en ? mem[x_rd_addr] : ~x_rd_data;
        y_rd_data <= y_rd_en ? mem[y_rd_addr] : ~y_rd_data;
        if (wr_valid && wr_ready) begin
            mem[wr.addr] <= wr.data;
        end
        wr_ready <= !hold && ($random(seed) & 3) != 0;
    end
endmodule

// ===== vpa_pkg.sv
// package for the pointwise vector arithmetic datapath
// assumes one clock, operand memory word of 32 bits, 16-bit pointers
package vpa_pkg;
    // ****************************************************
    // widths and command codes
    // ****************************************************
    localparam int ADDR_W = 16;                          // pointer width
    localparam int DATA_W = 32;                          // memory word width
    localparam int FIFO_DEPTH = 16;                      // result fifo depth
    localparam logic [7:0] OPC_PMUL = 8'h3c;             // packed_q15_multiply_cmd
    localparam logic [7:0] OPC_LMUL = 8'h74;             // q31_multiply_cmd
    localparam logic [7:0] OPC_CMUL = 8'h78;             // complex_q15_multiply_cmd
    localparam logic [7:0] OPC_PSUB = 8'h70;             // packed_16bit_subtract_cmd
    localparam logic [7:0] OPC_LSUB = 8'hd4;             // signed_32bit_subtract_cmd
    localparam logic [7:0] OPC_MAC = 8'h80;              // basic_multiply_accumulate_cmd
    // ****************************************************
    // fixed point limits and alignment
    // ****************************************************
    localparam logic [15:0] Q15_MAX = 16'h7fff;          // q15 one minus epsilon
    localparam logic [15:0] Q15_MIN = 16'h8000;          // q15 minus one
    localparam logic [31:0] Q31_MAX = 32'h7fffffff;      // q31 one minus epsilon
    localparam logic [31:0] Q31_MIN = 32'h80000000;      // q31 minus one
    localparam int Q15_FRAC = 15;                        // product shift for q15
    localparam int Q31_FRAC = 31;                        // product shift for q31
    localparam logic [15:0] PAIR_STEP = 16'h0002;        // mac walks element pairs
    localparam logic [16:0] CNT_ZERO = 17'h00000;        // empty step count
    localparam logic [16:0] CNT_ONE = 17'h00001;         // last step marker
    // ****************************************************
    // types
    // ****************************************************
    typedef enum logic [4:0] {
        VPA_IDLE = 5'h01,                                // waiting for a command
        VPA_READ = 5'h02,                                // operand reads issued
        VPA_CALC = 5'h04,                                // operands back, compute
        VPA_PUSH = 5'h08,                                // result into fifo
        VPA_FLUSH = 5'h10                                // wait for writes to drain
    } vpa_state_type;
    typedef struct packed {
        logic [7:0] opcode;                              // command code
        logic [15:0] x_ptr;                              // source x pointer
        logic [15:0] y_ptr;                              // source y pointer
        logic [15:0] z_ptr;                              // destination pointer
        logic [15:0] x_pointer_step;                     // signed x increment
        logic [15:0] y_pointer_step;                     // signed y increment
        logic [15:0] z_pointer_step;                     // signed z increment
        logic [15:0] count;                              // unsigned element count
    } vpa_cmd_type;
    typedef struct packed {
        logic [15:0] addr;                               // destination address
        logic [31:0] data;                               // result word
    } vpa_wr_type;
endpackage
